/* File: hw/wdfs_consts.vh */
`ifndef WDFS_CONSTS_VH
`define WDFS_CONSTS_VH
// Number of switched outputs and fault bits
`define WDFS_NUM_OUT      12
// Default watchdog timeout in clk_sys cycles
`define WDFS_TIMEOUT_CYC  100000
// Width of the timeout counter
`define WDFS_CNT_W        32
// Index of the first and third high-side outputs
`define WDFS_HS_A_BIT     0
`define WDFS_HS_C_BIT     2
// Width of the serial fault word
`define WDFS_WORD_W       16
`endif

/* File: hw/wdfs_watchdog_failsafe.v */
// Overview of operation
// - Missing watchdog toggle within the timeout window forces failsafe state.
// - Fault flag pin pulled low while any fault is latched, released once init low clears the latches.
// - Flag is summary only; per-output detail goes back in serial data.
// - On timeout, outputs follow the sampled failsafe-select level.
// - Select high: first and third high-side outputs turn on in failsafe.
// - Select low: watchdog and failsafe entry both disabled.
// - Init rising edge starts timeout; init low clears faults and counter, enters standby.
// - Wake input high starts the watchdog timeout from idle, not from standby.
// - Failsafe outputs stay on until reinitialised; then normal resumes.
// - Serial fault word bits 11..0 map to outputs 11..0.
`timescale 1ns/1ps
`include "wdfs_consts.vh"
`default_nettype none
module wdfs_watchdog_failsafe #(
  parameter integer NUM_OUT     = `WDFS_NUM_OUT,
  parameter integer TIMEOUT_CYC = `WDFS_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rstn,
  // Supervision pins
  input  wire                 watchdog_kick_in,
  input  wire                 failsafe_select_in,
  input  wire                 device_init_n,
  input  wire                 wake_in,
  // Normal output commands and fault detectors
  input  wire [NUM_OUT-1:0]   out_cmd,
  input  wire [NUM_OUT-1:0]   fault_det,
  // Switched output states and mode flags
  output reg  [NUM_OUT-1:0]   out_state,
  output reg                  failsafe_active,
  output reg                  standby,
  // Open-drain fault flag: pin output and enable
  output reg                  fault_flag_n_o,
  output reg                  fault_flag_n_oe,
  // Fault word for the serial return path
  output reg  [`WDFS_WORD_W-1:0] fault_word
);

  // One-hot supervisor states
  localparam [3:0] ST_STANDBY  = 4'h1;
  localparam [3:0] ST_IDLE     = 4'h2;
  localparam [3:0] ST_WATCH    = 4'h4;
  localparam [3:0] ST_FAILSAFE = 4'h8;
  localparam [`WDFS_CNT_W-1:0] TMO_LAST = TIMEOUT_CYC - 1;

  // State, counter, pin history and fault latches
  reg  [3:0]              state_reg;
  reg  [3:0]              state_next;
  reg  [`WDFS_CNT_W-1:0]  cnt_reg;
  reg  [`WDFS_CNT_W-1:0]  cnt_next;
  reg                     kick_prev_reg;
  reg                     init_prev_reg;
  reg                     fs_sel_reg;
  reg                     fs_sel_next;
  reg  [NUM_OUT-1:0]      fault_reg;
  reg  [NUM_OUT-1:0]      out_next;
  wire                    kick_edge;
  wire                    init_rise;
  wire                    wd_enable;
  wire                    any_fault;

  // Either edge of the kick counts as a toggle
  assign kick_edge = watchdog_kick_in ^ kick_prev_reg;
  assign init_rise = device_init_n & ~init_prev_reg;
  // Tying select low switches the watchdog off
  assign wd_enable = failsafe_select_in;
  assign any_fault = |fault_reg;

  // State and timeout counter decisions
  always @* begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    fs_sel_next = fs_sel_reg;
    case (state_reg)
      ST_STANDBY: begin
        cnt_next = {`WDFS_CNT_W{1'b0}};
        if (init_rise) begin
          state_next = wd_enable ? ST_WATCH : ST_IDLE;
        end
      end
      ST_IDLE: begin
        cnt_next = {`WDFS_CNT_W{1'b0}};
        if (wd_enable && wake_in) begin
          state_next = ST_WATCH;
        end
      end
      ST_WATCH: begin
        // A kick restarts the window; the window is counted from the
        // last edge seen, so kicks no more than TIMEOUT_CYC cycles apart never trip it
        if (!wd_enable) begin
          state_next = ST_IDLE;
          cnt_next   = {`WDFS_CNT_W{1'b0}};
        end else if (kick_edge) begin
          cnt_next = {`WDFS_CNT_W{1'b0}};
        end else if (cnt_reg >= TMO_LAST) begin
          state_next  = ST_FAILSAFE;
          fs_sel_next = failsafe_select_in;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_FAILSAFE: begin
        // Held until reinitialised through the init pin
        state_next = ST_FAILSAFE;
      end
      default: begin
        state_next = ST_STANDBY;
      end
    endcase
    // Low init pin overrides everything
    if (!device_init_n) begin
      state_next = ST_STANDBY;
      cnt_next   = {`WDFS_CNT_W{1'b0}};
    end
  end

  // Output pattern: failsafe pattern replaces commands
  always @* begin
    out_next = out_cmd;
    if (state_next == ST_STANDBY) begin
      out_next = {NUM_OUT{1'b0}};
    end else if (state_next == ST_FAILSAFE) begin
      out_next = {NUM_OUT{1'b0}};
      if (fs_sel_next) begin
        out_next[`WDFS_HS_A_BIT] = 1'b1;
        out_next[`WDFS_HS_C_BIT] = 1'b1;
      end
    end
  end

  // Supervisor state, timeout counter and captured select level
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= ST_STANDBY;
      cnt_reg    <= {`WDFS_CNT_W{1'b0}};
      fs_sel_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      fs_sel_reg <= fs_sel_next;
    end
  end

  // Pin history for the edge detectors; init history resets low, so an
  // init pin already high at reset release counts as a rising edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      kick_prev_reg <= 1'b0;
      init_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= watchdog_kick_in;
      init_prev_reg <= device_init_n;
    end
  end

  // Sticky fault latches; init low is a full clear and wins over a
  // detection in the same cycle, so such a detection is lost
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_reg <= {NUM_OUT{1'b0}};
    end else if (!device_init_n) begin
      fault_reg <= {NUM_OUT{1'b0}};
    end else begin
      fault_reg <= fault_reg | fault_det;
    end
  end

  // Output pattern and mode flags, registered so the pins never glitch
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_state       <= {NUM_OUT{1'b0}};
      failsafe_active <= 1'b0;
      standby         <= 1'b1;
    end else begin
      out_state       <= out_next;
      failsafe_active <= (state_next == ST_FAILSAFE);
      standby         <= (state_next == ST_STANDBY);
    end
  end

  // Open drain: data held low, enable only while pulling low;
  // the flag lags the fault latch by one cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= any_fault;
    end
  end

  // Serial return word: one bit per output, upper bits zero; it carries
  // the detail that the single flag cannot
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_word <= {`WDFS_WORD_W{1'b0}};
    end else begin
      fault_word <= {{(`WDFS_WORD_W-NUM_OUT){1'b0}}, fault_reg};
    end
  end

endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam integer TO = 20;
  logic clk_sys = 1'b0, rstn = 1'b0, sel = 1'b1, init_n = 1'b0, wake = 1'b0;
  logic [7:0]  gap = 8'h00;
  logic [11:0] cmd = 12'hA5A, det = 12'h000, outs;
  logic        kick, fsa, stby, fl_o, fl_oe;
  logic [15:0] word;
  integer n_mismatch = 0, comparisons = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  wdfs_mcu_model mcu (.clk_sys(clk_sys), .gap(gap), .kick(kick));
  wdfs_watchdog_failsafe #(.NUM_OUT(12), .TIMEOUT_CYC(TO)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .watchdog_kick_in(kick),
    .failsafe_select_in(sel), .device_init_n(init_n), .wake_in(wake),
    .out_cmd(cmd), .fault_det(det), .out_state(outs),
    .failsafe_active(fsa), .standby(stby), .fault_flag_n_o(fl_o),
    .fault_flag_n_oe(fl_oe), .fault_word(word));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait n edges, then step off the edge
  task automatic wt(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic reinit();
    init_n = 1'b0;
    wt(2);
    chk(16'(stby), 16'h0001);
    init_n = 1'b1;
    wt(2);
  endtask
  task automatic t_starve();
    gap = 8'd5;
    reinit();
    wt(3 * TO);
    chk(16'(fsa), 16'h0000);
    chk(16'(outs), 16'(cmd));
    gap = 8'd0;
    wt(TO - 6);
    chk(16'(fsa), 16'h0000);
    wt(8);
    chk(16'(outs), 16'h0005);
    sel = 1'b0;
    wt(3);
    chk(16'(fsa), 16'h0001);
    sel = 1'b1;
    reinit();
    chk(16'(outs), 16'(cmd));
    $display("starve test done");
  endtask
  task automatic t_sel_wake();
    sel = 1'b0;
    reinit();
    wt(2 * TO);
    chk(16'(fsa), 16'h0000);
    sel = 1'b1;
    wake = 1'b1;
    wt(1);
    wake = 1'b0;
    wt(TO + 3);
    chk(16'(fsa), 16'h0001);
    $display("select and wake test done");
  endtask
  task automatic t_fault();
    gap = 8'd5;
    reinit();
    det = 12'h821;
    wt(1);
    det = 12'h000;
    wt(3);
    chk({14'h0, fl_oe, fl_o}, 16'h0002);
    chk(word, 16'h0821);
    reinit();
    chk(16'(fl_oe), 16'h0000);
    $display("fault test done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    wt(16);
    rstn = 1'b1;
    t_starve();
    t_sel_wake();
    t_fault();
    end_of_test();
  end
  // Hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule
bind wdfs_watchdog_failsafe wdfs_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .watchdog_kick_in(watchdog_kick_in),
  .failsafe_select_in(failsafe_select_in), .device_init_n(device_init_n),
  .out_state(out_state), .failsafe_active(failsafe_active),
  .standby(standby), .fault_flag_n_o(fault_flag_n_o),
  .fault_flag_n_oe(fault_flag_n_oe), .fault_word(fault_word));
`default_nettype wire

/* File: verification/wdfs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wdfs_checker #(parameter integer TIMEOUT_CYC = 20) (
  // Pins watched
  input wire logic        clk_sys, rstn, watchdog_kick_in,
  input wire logic        failsafe_select_in, device_init_n,
  input wire logic [11:0] out_state,
  input wire logic        failsafe_active, standby,
  input wire logic        fault_flag_n_o, fault_flag_n_oe,
  input wire logic [15:0] fault_word
);
  logic        kick_reg;
  logic [31:0] quiet_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Cycles since the last kick edge; slack of two covers sampling skew
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      kick_reg  <= 1'b0;
      quiet_reg <= 32'h0;
    end else begin
      kick_reg  <= watchdog_kick_in;
      quiet_reg <= (kick_reg != watchdog_kick_in) ? 32'h0 : quiet_reg + 32'h1;
    end
  end
  kick_wait_a: assert property ($rose(failsafe_active) |->
    quiet_reg >= TIMEOUT_CYC - 2) else $error("early failsafe");
  fs_pattern_a: assert property (failsafe_active |-> out_state == 12'h005)
    else $error("failsafe pattern");
  sel_off_a: assert property (!failsafe_select_in && !failsafe_active |=>
    !failsafe_active) else $error("failsafe while disabled");
  init_low_a: assert property (!device_init_n |=> standby &&
    out_state == 12'h000 && !failsafe_active) else $error("init low");
  init_rise_a: assert property ($rose(device_init_n) |=> !standby)
    else $error("init rise");
  fs_hold_a: assert property (failsafe_active && device_init_n |=>
    failsafe_active) else $error("failsafe dropped");
  flag_sum_a: assert property (fault_flag_n_oe == (|fault_word) &&
    !fault_flag_n_o) else $error("fault flag");
  word_top_a: assert property (fault_word[15:12] == 4'h0)
    else $error("word top bits");
endmodule
`default_nettype wire

/* File: verification/wdfs_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdfs_mcu_model (
  // Clock and pacing, zero gap stops kicking
  input  wire logic       clk_sys,
  input  wire logic [7:0] gap,
  // Kick pin
  output var logic        kick
);
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] gap_seen = 8'h00;
  initial kick = 1'b0;
  // Take the gap on the edge, so a bench change after it never races
  always @(posedge clk_sys) begin
    gap_seen = gap;
    #1;
    cnt_reg = (cnt_reg >= gap_seen) ? 8'h00 : cnt_reg + 8'h01;
    if (gap_seen != 8'h00 && cnt_reg == 8'h00) kick = ~kick;
  end
endmodule
`default_nettype wire
